// >>> pcci_pkg.sv
// Package with codes, register map, field positions and limits of the card command interpreter.
package pcci_pkg;

	// Register offsets (byte addresses) and the code, block and byte-count field widths.
	localparam logic [3:0]  PCCI_REG_CMD     = 4'h0;
	localparam logic [3:0]  PCCI_REG_STATUS  = 4'h4;
	localparam logic [3:0]  PCCI_REG_BYTES   = 4'h8;
	localparam int          PCCI_CODE_W      = 14;
	localparam int          PCCI_BLK_W       = 10;
	localparam int          PCCI_BYTES_W     = 20;

	// Whole-code operation values and code families (thousands digit).
	localparam logic [13:0] PCCI_CODE_DIFF_BOOT = 14'h07D1; // 2001
	localparam logic [13:0] PCCI_CODE_WARN_CLR  = 14'h2553; // 9555
	localparam logic [13:0] PCCI_CODE_WARN_SET  = 14'h25C2; // 9666
	localparam logic [13:0] PCCI_CODE_RO_CLR    = 14'h2631; // 9777
	localparam logic [13:0] PCCI_CODE_RO_SET    = 14'h26A0; // 9888
	localparam logic [13:0] PCCI_CODE_ERASE_ALL = 14'h270F; // 9999
	localparam logic [13:0] PCCI_CODE_ZERO      = 14'h0000;
	localparam logic [13:0] PCCI_THOUSAND       = 14'h03E8;
	localparam logic [3:0]  PCCI_FAM_FULL       = 4'h3;
	localparam logic [3:0]  PCCI_FAM_DIFF       = 4'h4;
	localparam logic [3:0]  PCCI_FAM_PROG       = 4'h5;
	localparam logic [3:0]  PCCI_FAM_LOAD       = 4'h6;
	localparam logic [3:0]  PCCI_FAM_ERASE      = 4'h7;
	localparam logic [3:0]  PCCI_FAM_COMPARE    = 4'h8;

	// Block ranges: writable blocks first, read-only macro blocks above.
	localparam logic [9:0]  PCCI_BLK_BOOT    = 10'h001;
	localparam logic [9:0]  PCCI_BLK_MIN     = 10'h001;
	localparam logic [9:0]  PCCI_BLK_RW_MAX  = 10'h1F3; // 499
	localparam logic [9:0]  PCCI_BLK_MAX     = 10'h3E7; // 999

	// Card capacity limits in kilobytes and storage cost of one difference.
	localparam logic [9:0]  PCCI_CAP_MIN_KB  = 10'h004;
	localparam logic [9:0]  PCCI_CAP_MAX_KB  = 10'h200;
	localparam logic [19:0] PCCI_BYTES_PER_DIFF = 20'h0_0006;

	// Parameter filter constants.
	localparam logic [7:0]  PCCI_MENU_EXTRA  = 8'h14; // menu 20
	localparam logic [7:0]  PCCI_INDEX_ZERO  = 8'h00;

	// Lowest firmware version (BCD xx.yy.zz) that knows the warning codes.
	localparam logic [23:0] PCCI_FW_WARN_MIN = 24'h01_0700;

	// Trip codes.
	localparam logic [1:0]  PCCI_TRIP_NONE    = 2'h0;
	localparam logic [1:0]  PCCI_TRIP_REMOVED = 2'h1;
	localparam logic [1:0]  PCCI_TRIP_COMPARE = 2'h2;
	localparam logic [1:0]  PCCI_TRIP_RATING  = 2'h3;

	// Status register bit positions.
	localparam int PCCI_ST_BUSY    = 0;
	localparam int PCCI_ST_TRIP    = 1;
	localparam int PCCI_ST_TCODE   = 2;
	localparam int PCCI_ST_IGNORED = 4;
	localparam int PCCI_ST_FMTWARN = 5;
	localparam int PCCI_ST_RO      = 6;
	localparam int PCCI_ST_PRESENT = 7;

	typedef enum logic [3:0] {
		PCCI_OP_NONE,
		PCCI_OP_DIFF_BOOT,
		PCCI_OP_FULL_WR,
		PCCI_OP_DIFF_WR,
		PCCI_OP_PROG_WR,
		PCCI_OP_LOAD,
		PCCI_OP_ERASE_BLK,
		PCCI_OP_COMPARE,
		PCCI_OP_WARN_CLR,
		PCCI_OP_WARN_SET,
		PCCI_OP_RO_CLR,
		PCCI_OP_RO_SET,
		PCCI_OP_ERASE_ALL
	} pcci_op_t;

	typedef enum logic [1:0] {
		PCCI_S_IDLE,
		PCCI_S_START,
		PCCI_S_RUN
	} pcci_state_t;

endpackage

// >>> pcci_card_cmd.sv
// Card command interpreter: decodes the command code on drive reset and runs the card operation.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// Functional notes
// - A card operation starts only on drive reset with a code in the command register.
// - Code 2001 stores default differences as a bootable set in block 001.
// - Code 3yyy writes the full parameter set to block yyy.
// - Code 4yyy writes only differences from last defaults to block yyy.
// - Code 5yyy writes the onboard logic-program image to block yyy.
// - Code 7yyy erases block yyy; code 9999 erases the whole card.
// - Code 8yyy compares drive parameters with block yyy.
// - Code 6yyy loads block yyy into the drive.
// - Codes 9555/9666 clear/set warning suppression, only from firmware 01.07.00.
// - Code 9888 sets and 9777 clears the card read-only flag.
// - With card read-only set, only load codes and 9777 act.
// - The block field addresses blocks 001 through 999.
// - Blocks 1-499 are read-write; 500-999 are read-only macros.
// - Full set takes user-save, not not-copied; power-down-save never goes.
// - Each stored difference costs six bytes of card storage.
// - Difference transfers also take non-default menu 20 entries except entry zero.
// - The card is touched only while a commanded operation runs.
// - Card removal during a transfer raises a trip.
// - A transfer indicator is shown while a card transfer is active.
// - Cards from 4kB to 512kB are supported.
// - Compare results across different data formats are flagged unreliable.
// - Good compare zeroes the command; failed compare raises a compare trip.
// - Loading into a drive of different rating raises a rating trip.
module pcci_card_cmd
	import pcci_pkg::*;
#(
	parameter logic [23:0] FW_VERSION = 24'h01_0700
)
(
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	input  wire logic [3:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [31:0]             reg_rdata_r,
	input  wire logic                    drive_reset,
	input  wire logic                    card_present,
	input  wire logic                    card_read_only,
	input  wire logic [9:0]              card_capacity_kb,
	input  wire logic                    card_done,
	input  wire logic                    card_ok,
	input  wire logic                    card_rating_match,
	input  wire logic                    card_format_match,
	output logic                         card_sel_r,
	output logic                         card_start_r,
	output pcci_op_t                     card_op_r,
	output logic      [PCCI_BLK_W-1:0]   card_block_r,
	input  wire logic                    param_valid,
	input  wire logic [7:0]              param_menu,
	input  wire logic [7:0]              param_index,
	input  wire logic                    param_user_save,
	input  wire logic                    param_power_down_save,
	input  wire logic                    param_not_copied,
	input  wire logic                    param_is_default,
	output logic                         param_take_r,
	output logic                         card_transfer_indicator_r,
	output logic                         trip_r,
	output logic      [1:0]              trip_code_r
);

	pcci_state_t              state_r;
	logic [PCCI_CODE_W-1:0]   command_code_parameter_r;
	logic [PCCI_BYTES_W-1:0]  bytes_used_r;
	logic                     ignored_r;
	logic                     fmt_warn_r;
	pcci_op_t                 dec_op;
	logic [PCCI_BLK_W-1:0]    dec_blk;
	logic                     dec_ok;
	logic                     take_nxt;
	logic                     finish_ok;
	logic                     finish_bad;
	logic                     removed;

	// Thousands digit of a decimal command code.
	function automatic logic [3:0] code_family(input logic [13:0] code);
		logic [13:0] q;
		q = code / PCCI_THOUSAND;
		return q[3:0];
	endfunction

	// Three-digit block field of a decimal command code.
	function automatic logic [9:0] code_block(input logic [13:0] code);
		logic [13:0] r;
		r = code % PCCI_THOUSAND;
		return r[9:0];
	endfunction

	// True when the block number lies in the whole addressable range.
	function automatic logic blk_any(input logic [9:0] blk);
		return (blk >= PCCI_BLK_MIN) && (blk <= PCCI_BLK_MAX);
	endfunction

	// True when the block number may be written or erased.
	function automatic logic blk_writable(input logic [9:0] blk);
		return (blk >= PCCI_BLK_MIN) && (blk <= PCCI_BLK_RW_MAX);
	endfunction

	// Decode the command code into an operation, a block and an accept flag.
	// A code that fails any check keeps its operation but clears the accept
	// flag, so the card is never selected for it.
	always_comb
	begin
		dec_op  = PCCI_OP_NONE;
		dec_blk = code_block(command_code_parameter_r);
		dec_ok  = 1'b0;
		if (command_code_parameter_r == PCCI_CODE_DIFF_BOOT)
		begin
			dec_op  = PCCI_OP_DIFF_BOOT;
			dec_blk = PCCI_BLK_BOOT;
			dec_ok  = 1'b1;
		end
		else if (command_code_parameter_r == PCCI_CODE_WARN_CLR)
		begin
			dec_op = PCCI_OP_WARN_CLR;
			dec_ok = (FW_VERSION >= PCCI_FW_WARN_MIN);
		end
		else if (command_code_parameter_r == PCCI_CODE_WARN_SET)
		begin
			dec_op = PCCI_OP_WARN_SET;
			dec_ok = (FW_VERSION >= PCCI_FW_WARN_MIN);
		end
		else if (command_code_parameter_r == PCCI_CODE_RO_CLR)
		begin
			dec_op = PCCI_OP_RO_CLR;
			dec_ok = 1'b1;
		end
		else if (command_code_parameter_r == PCCI_CODE_RO_SET)
		begin
			dec_op = PCCI_OP_RO_SET;
			dec_ok = 1'b1;
		end
		else if (command_code_parameter_r == PCCI_CODE_ERASE_ALL)
		begin
			dec_op = PCCI_OP_ERASE_ALL;
			dec_ok = 1'b1;
		end
		else
		begin
			case (code_family(command_code_parameter_r))
				PCCI_FAM_FULL:
				begin
					dec_op = PCCI_OP_FULL_WR;
					dec_ok = blk_writable(dec_blk);
				end
				PCCI_FAM_DIFF:
				begin
					dec_op = PCCI_OP_DIFF_WR;
					dec_ok = blk_writable(dec_blk);
				end
				PCCI_FAM_PROG:
				begin
					dec_op = PCCI_OP_PROG_WR;
					dec_ok = blk_writable(dec_blk);
				end
				PCCI_FAM_LOAD:
				begin
					dec_op = PCCI_OP_LOAD;
					dec_ok = blk_any(dec_blk);
				end
				PCCI_FAM_ERASE:
				begin
					dec_op = PCCI_OP_ERASE_BLK;
					dec_ok = blk_writable(dec_blk);
				end
				PCCI_FAM_COMPARE:
				begin
					dec_op = PCCI_OP_COMPARE;
					dec_ok = blk_any(dec_blk);
				end
				default:
				begin
					dec_op = PCCI_OP_NONE;
					dec_ok = 1'b0;
				end
			endcase
		end
		// A read-only card lets only loads and the flag clear through.
		if (card_read_only && (dec_op != PCCI_OP_LOAD)
			&& (dec_op != PCCI_OP_RO_CLR))
		begin
			dec_ok = 1'b0;
		end
		// Cards outside the supported size range are left alone.
		if ((card_capacity_kb < PCCI_CAP_MIN_KB)
			|| (card_capacity_kb > PCCI_CAP_MAX_KB) || !card_present)
		begin
			dec_ok = 1'b0;
		end
	end

	// Completion and abort terms of a running operation.
	assign removed    = (state_r == PCCI_S_RUN) && !card_present;
	assign finish_ok  = (state_r == PCCI_S_RUN) && card_present && card_done
		&& card_ok && !((card_op_r == PCCI_OP_LOAD) && !card_rating_match);
	assign finish_bad = (state_r == PCCI_S_RUN) && card_present && card_done
		&& !finish_ok;

	// Sequencer: idle until a drive reset, one start cycle, then run to done.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= PCCI_S_IDLE;
		else
		begin
			case (state_r)
				PCCI_S_IDLE:
					if (drive_reset && dec_ok)
						state_r <= PCCI_S_START;
				PCCI_S_START:
					state_r <= PCCI_S_RUN;
				PCCI_S_RUN:
					if (card_done || removed)
						state_r <= PCCI_S_IDLE;
				default:
					state_r <= PCCI_S_IDLE;
			endcase
		end
	end

	// Card port: select stays high only for the length of the operation,
	// so the card can be swapped freely whenever the block is idle.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			card_sel_r   <= 1'b0;
			card_start_r <= 1'b0;
			card_op_r    <= PCCI_OP_NONE;
			card_block_r <= '0;
		end
		else
		begin
			card_start_r <= (state_r == PCCI_S_IDLE) && drive_reset && dec_ok;
			if ((state_r == PCCI_S_IDLE) && drive_reset && dec_ok)
			begin
				card_sel_r   <= 1'b1;
				card_op_r    <= dec_op;
				card_block_r <= dec_blk;
			end
			else if ((state_r == PCCI_S_RUN) && (card_done || removed))
			begin
				card_sel_r <= 1'b0;
				card_op_r  <= PCCI_OP_NONE;
			end
		end
	end

	// Transfer indicator rises with the card select, so the display never
	// lags the access window by the start cycle.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			card_transfer_indicator_r <= 1'b0;
		else
			card_transfer_indicator_r <= ((state_r == PCCI_S_IDLE)
				&& drive_reset && dec_ok) || ((state_r != PCCI_S_IDLE)
				&& !removed && !((state_r == PCCI_S_RUN) && card_done));
	end

	// Parameter filter for the outgoing stream during a parameter write.
	always_comb
	begin
		take_nxt = 1'b0;
		if (param_valid && (state_r == PCCI_S_RUN) && !param_power_down_save)
		begin
			case (card_op_r)
				PCCI_OP_FULL_WR:
					take_nxt = param_user_save && !param_not_copied;
				PCCI_OP_DIFF_WR, PCCI_OP_DIFF_BOOT:
					take_nxt = ((param_user_save && !param_not_copied)
						|| ((param_menu == PCCI_MENU_EXTRA)
						&& (param_index != PCCI_INDEX_ZERO)))
						&& !param_is_default;
				default:
					take_nxt = 1'b0;
			endcase
		end
	end

	// Registered take flag and storage count of the current block.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			param_take_r <= 1'b0;
			bytes_used_r <= '0;
		end
		else
		begin
			param_take_r <= take_nxt;
			if ((state_r == PCCI_S_IDLE) && drive_reset && dec_ok)
				bytes_used_r <= '0;
			else if (take_nxt && (card_op_r != PCCI_OP_FULL_WR))
				bytes_used_r <= bytes_used_r + PCCI_BYTES_PER_DIFF;
		end
	end

	// Trips stay until the next drive reset in idle, even one whose code is ignored.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trip_r      <= 1'b0;
			trip_code_r <= PCCI_TRIP_NONE;
		end
		else if (removed)
		begin
			trip_r      <= 1'b1;
			trip_code_r <= PCCI_TRIP_REMOVED;
		end
		else if (finish_bad && (card_op_r == PCCI_OP_LOAD) && card_ok
			&& !card_rating_match)
		begin
			trip_r      <= 1'b1;
			trip_code_r <= PCCI_TRIP_RATING;
		end
		else if (finish_bad && (card_op_r == PCCI_OP_COMPARE))
		begin
			trip_r      <= 1'b1;
			trip_code_r <= PCCI_TRIP_COMPARE;
		end
		else if ((state_r == PCCI_S_IDLE) && drive_reset)
		begin
			trip_r      <= 1'b0;
			trip_code_r <= PCCI_TRIP_NONE;
		end
	end

	// Ignored-command and format-warning status flags.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ignored_r  <= 1'b0;
			fmt_warn_r <= 1'b0;
		end
		else
		begin
			if ((state_r == PCCI_S_IDLE) && drive_reset)
				ignored_r <= !dec_ok;
			if ((state_r == PCCI_S_IDLE) && drive_reset)
				fmt_warn_r <= 1'b0;
			else if ((state_r == PCCI_S_RUN) && card_done
				&& (card_op_r == PCCI_OP_COMPARE))
				fmt_warn_r <= !card_format_match;
		end
	end

	// Command register; a software write beats the hardware clear so that a
	// new code written as an operation ends is never lost.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			command_code_parameter_r <= PCCI_CODE_ZERO;
		else if (reg_wr && (reg_addr == PCCI_REG_CMD))
			command_code_parameter_r <= reg_wdata[PCCI_CODE_W-1:0];
		else if (finish_ok)
			command_code_parameter_r <= PCCI_CODE_ZERO;
	end

	// Read data, valid the cycle after the read strobe; unmapped reads zero.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_r <= '0;
		else
		begin
			reg_rdata_r <= '0;
			if (reg_rd)
			begin
				case (reg_addr)
					PCCI_REG_CMD:
						reg_rdata_r[PCCI_CODE_W-1:0] <= command_code_parameter_r;
					PCCI_REG_STATUS:
					begin
						reg_rdata_r[PCCI_ST_BUSY]    <= (state_r != PCCI_S_IDLE);
						reg_rdata_r[PCCI_ST_TRIP]    <= trip_r;
						reg_rdata_r[PCCI_ST_TCODE+1:PCCI_ST_TCODE] <= trip_code_r;
						reg_rdata_r[PCCI_ST_IGNORED] <= ignored_r;
						reg_rdata_r[PCCI_ST_FMTWARN] <= fmt_warn_r;
						reg_rdata_r[PCCI_ST_RO]      <= card_read_only;
						reg_rdata_r[PCCI_ST_PRESENT] <= card_present;
					end
					PCCI_REG_BYTES:
						reg_rdata_r[PCCI_BYTES_W-1:0] <= bytes_used_r;
					default:
						reg_rdata_r <= '0;
				endcase
			end
		end
	end

endmodule

// >>> pcci_card_cmd_assertions.sv
// Port checker for the card command interpreter, bound to its top module.
`timescale 1ns/1ps
module pcci_card_cmd_chk
	import pcci_pkg::*;
(
	input wire logic            core_clk,
	input wire logic            rst_n,
	input wire logic            drive_reset,
	input wire logic            card_present,
	input wire logic            card_read_only,
	input wire logic            card_done,
	input wire logic            card_ok,
	input wire logic            card_rating_match,
	input wire logic            param_valid,
	input wire logic            param_power_down_save,
	input wire logic            card_sel_r,
	input wire logic            card_start_r,
	input wire pcci_op_t        card_op_r,
	input wire logic [9:0]      card_block_r,
	input wire logic            param_take_r,
	input wire logic            card_transfer_indicator_r,
	input wire logic            trip_r,
	input wire logic [1:0]      trip_code_r
);
	wire logic run_w;

	// Running means selected after the start cycle, when done is honoured.
	assign run_w = card_sel_r && !card_start_r;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Only a drive reset may open the card window.
	launch_rst_a: assert property ($rose(card_sel_r)
		|-> card_start_r && $past(drive_reset))
		else $error("card window opened without drive reset");
	indicator_a: assert property (
		card_transfer_indicator_r == card_sel_r)
		else $error("transfer indicator differs from card window");
	boot_block_a: assert property (card_start_r
		&& card_op_r == PCCI_OP_DIFF_BOOT |-> card_block_r == PCCI_BLK_BOOT)
		else $error("bootable set not aimed at first block");
	// Writes and erases must stay inside the writable range.
	write_range_a: assert property (card_start_r
		&& card_op_r inside {PCCI_OP_FULL_WR, PCCI_OP_DIFF_WR,
		PCCI_OP_PROG_WR, PCCI_OP_ERASE_BLK}
		|-> card_block_r inside {[PCCI_BLK_MIN:PCCI_BLK_RW_MAX]})
		else $error("write to a protected block");
	ro_gate_a: assert property (card_start_r
		&& $past(card_read_only)
		|-> card_op_r inside {PCCI_OP_LOAD, PCCI_OP_RO_CLR})
		else $error("operation launched on a locked card");
	removal_trip_a: assert property (run_w && !card_present
		&& !card_done |=> trip_r && trip_code_r == PCCI_TRIP_REMOVED
		&& !card_sel_r)
		else $error("card removal not tripped");
	cmp_trip_a: assert property (run_w && card_present
		&& card_done && !card_ok && card_op_r == PCCI_OP_COMPARE
		|=> trip_r && trip_code_r == PCCI_TRIP_COMPARE)
		else $error("failed compare not tripped");
	rating_trip_a: assert property (run_w && card_present
		&& card_done && card_ok && !card_rating_match
		&& card_op_r == PCCI_OP_LOAD
		|=> trip_r && trip_code_r == PCCI_TRIP_RATING)
		else $error("rating mismatch not tripped");
	take_cause_a: assert property (param_take_r
		|-> $past(param_valid) && !$past(param_power_down_save))
		else $error("parameter taken without a valid saveable descriptor");

	// Main scenarios reached.
	cover property (card_start_r && card_op_r == PCCI_OP_COMPARE);
	cover property (trip_r && trip_code_r == PCCI_TRIP_REMOVED);
	cover property (param_take_r && card_op_r == PCCI_OP_DIFF_WR);
endmodule

bind pcci_card_cmd pcci_card_cmd_chk i_pcci_card_cmd_chk (.*);

// >>> pcci_card_model.sv
// Behavioural model of the removable parameter card.
`timescale 1ns/1ps
module pcci_card_model
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       card_sel_r,
	input  wire logic       card_start_r,
	input  wire logic [7:0] p_lat,
	input  wire logic [2:0] p_res,
	output logic            card_done,
	output logic            card_ok,
	output logic            card_rating_match,
	output logic            card_format_match
);
	logic [7:0] cnt_r;

	// Count from the start pulse; deselection abandons the job at once.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 8'h00;
		else if (card_start_r)
			cnt_r <= 8'h01;
		else if (card_sel_r && cnt_r != 8'h00 && cnt_r != p_lat)
			cnt_r <= cnt_r + 8'h01;
		else
			cnt_r <= 8'h00;
	end

	// Results mean nothing outside done, so they toggle there to expose misuse.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			card_done <= 1'b0;
			{card_ok, card_rating_match, card_format_match} <= 3'h0;
		end
		else
		begin
			card_done <= card_sel_r && !card_start_r && cnt_r == p_lat;
			if (card_sel_r && !card_start_r && cnt_r == p_lat)
				{card_ok, card_rating_match, card_format_match} <= p_res;
			else
				{card_ok, card_rating_match, card_format_match} <=
					~{card_ok, card_rating_match, card_format_match};
		end
	end
endmodule

// >>> pcci_card_cmd_tb.sv
// Self-checking bench for the card command interpreter.
`timescale 1ns/1ps
module pcci_card_cmd_tb;
	import pcci_pkg::*;
	logic        core_clk, rst_n, reg_wr, reg_rd, drive_reset;
	logic        card_present, card_read_only, card_done, card_ok;
	logic        card_rating_match, card_format_match, param_valid;
	logic        param_user_save, param_power_down_save, param_not_copied;
	logic        param_is_default, card_sel_r, card_start_r, param_take_r;
	logic        card_transfer_indicator_r, trip_r, chk_t, exp_t;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata_r, rd_v, lfsr, ps;
	logic [9:0]  card_capacity_kb, card_block_r;
	logic [7:0]  param_menu, param_index, p_lat;
	logic [2:0]  p_res;
	logic [1:0]  trip_code_r, et;
	pcci_op_t    card_op_r, e_op;
	int          n_mismatch, n_tests, n_take;
	logic [13:0] codes [16] = '{14'h07D1, 14'h0BB9, 14'h0DAB, 14'h0DAC,
		14'h0FAA, 14'h138A, 14'h1B57, 14'h1D4B, 14'h1B58, 14'h1F4A,
		PCCI_CODE_WARN_CLR, PCCI_CODE_WARN_SET, PCCI_CODE_RO_SET,
		PCCI_CODE_RO_CLR, PCCI_CODE_ERASE_ALL, 14'h04D2};

	pcci_card_cmd i_pcci_card_cmd (.*);
	pcci_card_model i_pcci_card_model (.*);

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected decode, including the card, capacity and lock gates.
	function automatic pcci_op_t exp_op(input logic [13:0] c);
		logic [13:0] f, b;
		pcci_op_t    o;
		f = c / PCCI_THOUSAND;
		b = c % PCCI_THOUSAND;
		o = PCCI_OP_NONE;
		case (f[3:0])
			PCCI_FAM_FULL: o = PCCI_OP_FULL_WR;
			PCCI_FAM_DIFF: o = PCCI_OP_DIFF_WR;
			PCCI_FAM_PROG: o = PCCI_OP_PROG_WR;
			PCCI_FAM_LOAD: o = PCCI_OP_LOAD;
			PCCI_FAM_ERASE: o = PCCI_OP_ERASE_BLK;
			PCCI_FAM_COMPARE: o = PCCI_OP_COMPARE;
			default: o = PCCI_OP_NONE;
		endcase
		if (b == 14'h0000 || (b > 14'(PCCI_BLK_RW_MAX) &&
			!(o inside {PCCI_OP_LOAD, PCCI_OP_COMPARE})) || f > 14'h0009)
			o = PCCI_OP_NONE;
		case (c)
			PCCI_CODE_DIFF_BOOT: o = PCCI_OP_DIFF_BOOT;
			PCCI_CODE_WARN_CLR: o = PCCI_OP_WARN_CLR;
			PCCI_CODE_WARN_SET: o = PCCI_OP_WARN_SET;
			PCCI_CODE_RO_CLR: o = PCCI_OP_RO_CLR;
			PCCI_CODE_RO_SET: o = PCCI_OP_RO_SET;
			PCCI_CODE_ERASE_ALL: o = PCCI_OP_ERASE_ALL;
			default: ;
		endcase
		if ((card_read_only && !(o inside {PCCI_OP_LOAD, PCCI_OP_RO_CLR}))
			|| !card_present || card_capacity_kb < PCCI_CAP_MIN_KB
			|| card_capacity_kb > PCCI_CAP_MAX_KB)
			o = PCCI_OP_NONE;
		return o;
	endfunction

	// Whether the descriptor now on the stream should reach the card.
	function automatic logic exp_take();
		logic d;
		d = param_user_save && !param_not_copied;
		if (e_op != PCCI_OP_FULL_WR)
			d = !param_is_default && (d || (param_menu == PCCI_MENU_EXTRA
				&& param_index != PCCI_INDEX_ZERO));
		return param_valid && card_sel_r && !card_start_r && d &&
			!param_power_down_save && e_op inside {PCCI_OP_FULL_WR,
			PCCI_OP_DIFF_WR, PCCI_OP_DIFF_BOOT};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		rd_v = reg_rdata_r;
	endtask

	// Launch one code; pull removes the card in mid-transfer.
	task automatic cmd(input logic [13:0] c, input logic pull);
		int k;
		wr(PCCI_REG_CMD, {18'h0_0000, c});
		e_op = exp_op(c);
		n_take = 0;
		@(posedge core_clk);
		drive_reset <= 1'b1;
		@(posedge core_clk);
		drive_reset <= 1'b0;
		@(posedge core_clk);
		chk(32'(card_start_r), 32'(e_op != PCCI_OP_NONE));
		chk(32'(card_transfer_indicator_r), 32'(e_op != PCCI_OP_NONE));
		chk(32'(card_op_r), 32'(e_op));
		if (e_op inside {[PCCI_OP_FULL_WR:PCCI_OP_COMPARE]})
			chk(32'(card_block_r), 32'(c % PCCI_THOUSAND));
		if (e_op == PCCI_OP_NONE)
		begin
			rd(PCCI_REG_STATUS);
			chk(32'(rd_v[PCCI_ST_IGNORED]), 32'h0000_0001);
			return;
		end
		if (pull)
		begin
			repeat (3) @(posedge core_clk);
			card_present <= 1'b0;
		end
		for (k = 0; k < 400 && card_sel_r; k++)
		begin
			@(posedge core_clk);
		end
		chk(32'(card_transfer_indicator_r), 32'h0000_0000);
		et = pull ? PCCI_TRIP_REMOVED : (!p_res[2] && e_op == PCCI_OP_COMPARE)
			? PCCI_TRIP_COMPARE : (p_res[2:1] == 2'b10 && e_op == PCCI_OP_LOAD)
			? PCCI_TRIP_RATING : PCCI_TRIP_NONE;
		rd(PCCI_REG_STATUS);
		chk(32'(rd_v[3:1]), 32'({et, et != PCCI_TRIP_NONE}));
		chk(32'(rd_v[PCCI_ST_BUSY]), 32'h0000_0000);
		if (e_op == PCCI_OP_COMPARE)
			chk(32'(rd_v[PCCI_ST_FMTWARN]), 32'(!p_res[0]));
		rd(PCCI_REG_CMD);
		if (et == PCCI_TRIP_COMPARE)
			chk(rd_v, 32'(c));
		else if (et == PCCI_TRIP_NONE && p_res[2])
			chk(rd_v, 32'h0000_0000);
		if (e_op inside {PCCI_OP_DIFF_WR, PCCI_OP_DIFF_BOOT} && p_res[2])
		begin
			rd(PCCI_REG_BYTES);
			chk(rd_v, 32'(n_take) * 32'(PCCI_BYTES_PER_DIFF));
		end
	endtask

	task final_report;
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Random descriptor stream and a one-cycle-late check of the take flag.
	always @(posedge core_clk)
	begin
		if (rst_n && chk_t)
			chk(32'(param_take_r), 32'(exp_t));
		if (chk_t && exp_t)
			n_take++;
		chk_t <= rst_n;
		exp_t <= exp_take();
		ps = nxt(ps);
		param_valid <= ps[0];
		param_menu <= ps[1] ? PCCI_MENU_EXTRA : ps[15:8];
		param_index <= ps[2] ? PCCI_INDEX_ZERO : ps[23:16];
		{param_user_save, param_power_down_save} <= ps[5:4];
		{param_not_copied, param_is_default} <= ps[7:6];
	end

	initial
	begin
		#600_000;
		n_mismatch++;
		final_report;
	end

	initial
	begin
		{rst_n, reg_wr, reg_rd, drive_reset, card_read_only, chk_t} = 6'h00;
		{param_valid, param_user_save, param_power_down_save} = 3'h0;
		{param_not_copied, param_is_default, exp_t} = 3'h0;
		{param_menu, param_index, reg_addr, reg_wdata} = 52'h0;
		{card_present, card_capacity_kb, p_lat, p_res} = {1'b1, 10'h040,
			8'h05, 3'h7};
		{lfsr, ps} = {32'h0000_7C86, 32'h0000_7C86};
		n_mismatch = 0;
		n_tests = 0;
		n_take = 0;
		e_op = PCCI_OP_NONE;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(PCCI_REG_STATUS);
		chk(rd_v, 32'h0000_0080);
		wr(PCCI_REG_STATUS, 32'hFFFF_FFFF);
		rd(4'hC);
		chk(rd_v, 32'h0000_0000);
		foreach (codes[i])
			cmd(codes[i], 1'b0);
		card_read_only <= 1'b1;
		cmd(14'h0BBD, 1'b0);
		cmd(14'h1775, 1'b0);
		cmd(PCCI_CODE_RO_CLR, 1'b0);
		card_read_only <= 1'b0;
		card_capacity_kb <= 10'h003;
		cmd(14'h0BBD, 1'b0);
		card_capacity_kb <= PCCI_CAP_MAX_KB;
		cmd(14'h0BBD, 1'b0);
		p_res = 3'b011;
		cmd(14'h1F4A, 1'b0);
		p_res = 3'b101;
		cmd(14'h1775, 1'b0);
		{p_res, p_lat} = {3'h7, 8'h40};
		cmd(14'h0BBD, 1'b1);
		card_present <= 1'b1;
		repeat (80)
		begin
			lfsr = nxt(lfsr);
			card_read_only <= lfsr[31:30] == 2'b11;
			{p_lat, p_res} = {8'(lfsr[25:20]) + 8'h01, lfsr[28:26]};
			cmd((14'(lfsr[2:0]) + 14'h0002) * PCCI_THOUSAND +
				14'(lfsr[17:8] % 10'(PCCI_THOUSAND)), 1'b0);
		end
		final_report;
	end
endmodule
